// ===== verilog/pcics_regs.v
// Configuration register bank for the card-information pointer, subsystem id
// and power capability pointer. Assumes a configuration-cycle front end that
// presents one-cycle read and write strobes with a dword byte address, and a
// serial EEPROM loader that presents one-cycle load strobes.
// The strap level is latched once per global reset; moving the pin later has
// no effect until the next reset.
// Neighbouring blocks supply the base register and power-management words,
// and see the mode and the masked base through registered outputs.
//
// Overview of operation
// - Strap high at reset: pointer register read-only, reads all zeros.
// - Image-number bits 31-28 of the pointer always read zero.
// - Bits 27-3 report structure offset; bits 7-3 come from EEPROM.
// - Strap low at reset: structure reads fetch EEPROM data at the low PCI address byte.
// - Strap low at reset: address-space field reads 011b.
// - Strap high at reset: address-space field reads 000b.
// - 011b points at the structure base register at offset 18h.
// - Subsystem id loads from EEPROM or from writes via offset F8h.
// - Device code in 31-16, vendor code 15-0, updated by EEPROM load or F8h write.
// - Power capability pointer is read-only and reads 44h.
// - Power-management registers live at dwords 44h and 48h.
// - Strap high at reset: structure base register reads all zeros.
`timescale 1ns/10ps
`include "pcics_defines.vh"

module pcics_regs (
  // Clock and global reset
  input  wire        clk_i,
  input  wire        rst_n_i,
  // Mode strap, sampled at reset release
  input  wire        card_mode_strap_i,
  // Configuration access
  input  wire        cfg_rd_i,
  input  wire        cfg_wr_i,
  input  wire [7:0]  cfg_addr_i,
  input  wire [31:0] cfg_wdata_i,
  output reg  [31:0] cfg_rdata_o,
  output reg         cfg_rvalid_o,
  // Serial EEPROM loader
  input  wire        eeprom_offset_load_i,
  input  wire [4:0]  eeprom_info_offset_i,
  input  wire        eeprom_subsys_load_i,
  input  wire [31:0] eeprom_subsys_i,
  // Structure fetch from the memory-space side
  input  wire        info_rd_i,
  input  wire [31:0] info_pci_addr_i,
  output reg         eeprom_fetch_o,
  output reg  [7:0]  eeprom_addr_o,
  // Neighbouring blocks
  output reg  [31:0] info_base_rdata_o,
  input  wire [31:0] info_base_reg_i,
  input  wire [31:0] pm_first_rdata_i,
  input  wire [31:0] pm_second_rdata_i,
  output reg         card_mode_o
);

  // Strap capture states: wait for the first edge, then hold until reset
  localparam [0:0] STRAP_WAIT = 1'h0;
  localparam [0:0] STRAP_HELD = 1'h1;

  // Base register bits that the host may program
  localparam [31:0] BASE_MASK = `PCICS_BASE_ADDR_MASK;

  // Strap capture state
  reg         strap_state;
  reg         next_strap_state;
  reg         card_mode;
  reg         next_card_mode;

  // Offset bits and subsystem id storage
  reg  [4:0]  info_struct_offset;
  reg  [4:0]  next_info_struct_offset;
  reg  [15:0] subsys_device_code;
  reg  [15:0] subsys_vendor_code;
  reg  [15:0] next_subsys_device_code;
  reg  [15:0] next_subsys_vendor_code;

  // Read answer
  reg  [31:0] next_rdata;
  reg         next_rvalid;

  // Structure fetch request
  reg         next_eeprom_fetch;
  reg  [7:0]  next_eeprom_addr;

  // Registered views for neighbouring blocks
  reg  [31:0] next_info_base_rdata;
  reg         next_mode_view;

  // Configuration address decode
  wire        hit_info_ptr;
  wire        hit_subsys;
  wire        hit_power_cap;
  wire        hit_info_base;
  wire        hit_pm_first;
  wire        hit_pm_second;
  wire        hit_subsys_acc;
  wire        subsys_acc_wr;

  // Pointer word fields
  wire [3:0]  image_field;
  wire [19:0] offset_high_field;
  wire [4:0]  offset_low_field;
  wire [2:0]  info_space_select;
  wire [31:0] info_ptr_word;

  // Fixed and masked read words
  wire [31:0] power_cap_word;
  wire [31:0] base_view;

  // Strap capture: take the pin level once, on the first edge after reset.
  // Sampling after release keeps the level clear of the reset edge itself;
  // a strap that moves later is ignored until the next reset.
  always @* begin
    next_strap_state = strap_state;
    next_card_mode   = card_mode;
    case (strap_state)
      STRAP_WAIT: begin
        next_strap_state = STRAP_HELD;
        next_card_mode   = card_mode_strap_i;
      end
      STRAP_HELD: begin
        next_strap_state = STRAP_HELD;
        next_card_mode   = card_mode;
      end
      default: begin
        next_strap_state = STRAP_WAIT;
        next_card_mode   = `PCICS_BIT_LOW;
      end
    endcase
  end

  // Strap state registers; the mode only changes at global reset
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_state <= STRAP_WAIT;
      card_mode   <= `PCICS_BIT_LOW;
    end else begin
      strap_state <= next_strap_state;
      card_mode   <= next_card_mode;
    end
  end

  // Configuration address decode, one hit per dword of interest
  assign hit_info_ptr   = (cfg_addr_i == `PCICS_OFF_INFO_PTR);
  assign hit_subsys     = (cfg_addr_i == `PCICS_OFF_SUBSYS);
  assign hit_power_cap  = (cfg_addr_i == `PCICS_OFF_POWER_CAP);
  assign hit_info_base  = (cfg_addr_i == `PCICS_OFF_INFO_BASE);
  assign hit_pm_first   = (cfg_addr_i == `PCICS_OFF_PM_FIRST);
  assign hit_pm_second  = (cfg_addr_i == `PCICS_OFF_PM_SECOND);
  assign hit_subsys_acc = (cfg_addr_i == `PCICS_OFF_SUBSYS_ACC);

  // Only the access register takes writes; 28h, 2Ch and 34h drop them
  assign subsys_acc_wr = cfg_wr_i & hit_subsys_acc;

  // Offset bits come from the EEPROM loader alone
  always @* begin
    next_info_struct_offset = info_struct_offset;
    if (eeprom_offset_load_i) begin
      next_info_struct_offset = eeprom_info_offset_i;
    end
  end

  // Offset register; a missing EEPROM leaves the structure at offset zero
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      info_struct_offset <= `PCICS_RST_OFFSET;
    end else begin
      info_struct_offset <= next_info_struct_offset;
    end
  end

  // Subsystem id: an EEPROM load wins over an access write in the same cycle
  always @* begin
    next_subsys_device_code = subsys_device_code;
    next_subsys_vendor_code = subsys_vendor_code;
    if (eeprom_subsys_load_i) begin
      next_subsys_device_code = eeprom_subsys_i[`PCICS_DEV_MSB:`PCICS_DEV_LSB];
      next_subsys_vendor_code = eeprom_subsys_i[`PCICS_VEN_MSB:`PCICS_VEN_LSB];
    end else if (subsys_acc_wr) begin
      next_subsys_device_code = cfg_wdata_i[`PCICS_DEV_MSB:`PCICS_DEV_LSB];
      next_subsys_vendor_code = cfg_wdata_i[`PCICS_VEN_MSB:`PCICS_VEN_LSB];
    end
  end

  // Subsystem id registers
  // The id resets to zero and stays there until the loader or host fills it
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      subsys_device_code <= `PCICS_RST_CODE;
      subsys_vendor_code <= `PCICS_RST_CODE;
    end else begin
      subsys_device_code <= next_subsys_device_code;
      subsys_vendor_code <= next_subsys_vendor_code;
    end
  end

  // Pointer fields: no ROM image, and the offset stays below 100h
  assign image_field       = `PCICS_IMAGE_NUM;
  assign offset_high_field = `PCICS_OFFSET_HIGH;
  assign offset_low_field  = info_struct_offset;

  // Address-space indicator from the captured strap
  assign info_space_select = card_mode ? `PCICS_SPACE_NONE
                                       : `PCICS_SPACE_BASE_REG;

  // Whole pointer word; zero when the strap selected the other mode
  assign info_ptr_word = card_mode ? `PCICS_ZERO_WORD
                       : {image_field, offset_high_field, offset_low_field, info_space_select};

  // Power capability pointer widened to a dword
  assign power_cap_word = {`PCICS_CAP_PAD, `PCICS_POWER_CAP_VAL};

  // Base register view: programmable bits pass only in the low-strap mode.
  // Bits 10-0 always read zero, which sizes the window at 2K bytes.
  genvar bit_idx;
  generate
    for (bit_idx = 0; bit_idx < `PCICS_WORD_W; bit_idx = bit_idx + 1) begin : gen_base_bit
      if (BASE_MASK[bit_idx]) begin : gen_kept
        assign base_view[bit_idx] = info_base_reg_i[bit_idx] & ~card_mode;
      end else begin : gen_fixed
        assign base_view[bit_idx] = `PCICS_BIT_LOW;
      end
    end
  endgenerate

  // Read decode; unmapped dwords read as zero.
  // Writes never reach this path, so read-only words cannot be disturbed.
  always @* begin
    next_rdata = `PCICS_ZERO_WORD;
    if (hit_info_ptr) begin
      next_rdata = info_ptr_word;
    end else if (hit_subsys) begin
      next_rdata = {subsys_device_code, subsys_vendor_code};
    end else if (hit_power_cap) begin
      next_rdata = power_cap_word;
    end else if (hit_info_base) begin
      next_rdata = base_view;
    end else if (hit_pm_first) begin
      next_rdata = pm_first_rdata_i;
    end else if (hit_pm_second) begin
      next_rdata = pm_second_rdata_i;
    end else begin
      next_rdata = `PCICS_ZERO_WORD;
    end
  end

  // Read data holds between reads; valid is a one-cycle pulse
  always @* begin
    next_rvalid = cfg_rd_i;
  end

  // Registered read answer, one cycle after the strobe
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_rdata_o  <= `PCICS_ZERO_WORD;
      cfg_rvalid_o <= `PCICS_BIT_LOW;
    end else begin
      cfg_rvalid_o <= next_rvalid;
      if (cfg_rd_i) begin
        cfg_rdata_o <= next_rdata;
      end
    end
  end

  // Structure fetch: no request while the strap disables the structure.
  // A fetch then would read a structure that the host cannot see.
  always @* begin
    next_eeprom_fetch = info_rd_i & ~card_mode;
    next_eeprom_addr  = eeprom_addr_o;
    if (info_rd_i) begin
      next_eeprom_addr = info_pci_addr_i[`PCICS_EADDR_MSB:`PCICS_EADDR_LSB];
    end
  end

  // Fetch registers; the address holds until the next structure read
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      eeprom_fetch_o <= `PCICS_BIT_LOW;
      eeprom_addr_o  <= `PCICS_RST_ADDR;
    end else begin
      eeprom_fetch_o <= next_eeprom_fetch;
      eeprom_addr_o  <= next_eeprom_addr;
    end
  end

  // Views handed to the base register and the rest of the unit
  always @* begin
    next_info_base_rdata = base_view;
    next_mode_view       = card_mode;
  end

  // Registered copies for neighbouring blocks
  // Registering these keeps every output straight from a flip-flop
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      info_base_rdata_o <= `PCICS_ZERO_WORD;
      card_mode_o       <= `PCICS_BIT_LOW;
    end else begin
      info_base_rdata_o <= next_info_base_rdata;
      card_mode_o       <= next_mode_view;
    end
  end

endmodule // pcics_regs

// ===== verilog/pcics_defines.vh
// Constants for the configuration-header slice covering offsets 18h to 48h, plus the F8h access dword.
// Included by the register-bank module; holds definitions only.
`ifndef PCICS_DEFINES_VH
`define PCICS_DEFINES_VH

// Configuration dword offsets (byte addresses)
`define PCICS_OFF_INFO_PTR     8'h28
`define PCICS_OFF_SUBSYS       8'h2C
`define PCICS_OFF_POWER_CAP    8'h34
`define PCICS_OFF_INFO_BASE    8'h18
`define PCICS_OFF_PM_FIRST     8'h44
`define PCICS_OFF_PM_SECOND    8'h48
`define PCICS_OFF_SUBSYS_ACC   8'hF8

// Constant field values
`define PCICS_SPACE_BASE_REG   3'h3
`define PCICS_SPACE_NONE       3'h0
`define PCICS_IMAGE_NUM        4'h0
`define PCICS_OFFSET_HIGH      20'h0_0000
`define PCICS_ZERO_WORD        32'h0000_0000
`define PCICS_POWER_CAP_VAL    8'h44
`define PCICS_BASE_ADDR_MASK   32'hFFFF_F800
`define PCICS_CAP_PAD          24'h00_0000

// Reset values and single-bit levels
`define PCICS_RST_OFFSET       5'h00
`define PCICS_RST_CODE         16'h0000
`define PCICS_RST_ADDR         8'h00
`define PCICS_BIT_LOW          1'h0

// Field positions and word width
`define PCICS_WORD_W           32
`define PCICS_DEV_MSB          31
`define PCICS_DEV_LSB          16
`define PCICS_VEN_MSB          15
`define PCICS_VEN_LSB          0
`define PCICS_EADDR_MSB        7
`define PCICS_EADDR_LSB        0

`endif

// ===== verification/pcics_regs_sva.sv
// Port assertions for the pcics_regs configuration bank.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/10ps
module pcics_regs_sva (
  // Clock, reset and captured mode
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        card_mode_o,
  // Configuration reads
  input wire logic        cfg_rd_i,
  input wire logic [7:0]  cfg_addr_i,
  input wire logic [31:0] cfg_rdata_o,
  input wire logic [31:0] pm_first_rdata_i,
  // Structure fetch and base view
  input wire logic        info_rd_i,
  input wire logic [31:0] info_pci_addr_i,
  input wire logic        eeprom_fetch_o,
  input wire logic [7:0]  eeprom_addr_o,
  input wire logic [31:0] info_base_rdata_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire ptr_rd = cfg_rd_i && cfg_addr_i == 8'h28;
  // Read answers one cycle after the strobe
  chk_power_ptr: assert property (cfg_rd_i && cfg_addr_i == 8'h34 |=> cfg_rdata_o == 32'h0000_0044)
    else $error("bad power pointer");
  chk_ptr_image: assert property (ptr_rd |=> cfg_rdata_o[31:28] == 4'h0)
    else $error("bad image field");
  chk_ptr_space: assert property (ptr_rd |=> cfg_rdata_o[2:0] == (card_mode_o ? 3'h0 : 3'h3))
    else $error("bad space field");
  chk_ptr_zero: assert property (ptr_rd && card_mode_o |=> cfg_rdata_o == 32'h0000_0000)
    else $error("pointer not zero");
  chk_pm_first: assert property (cfg_rd_i && cfg_addr_i == 8'h44 |=> cfg_rdata_o == $past(pm_first_rdata_i))
    else $error("bad pm word");
  chk_rdata_hold: assert property (!cfg_rd_i |=> $stable(cfg_rdata_o))
    else $error("read data moved");
  // Fetch and base view
  chk_fetch_addr: assert property (info_rd_i && !card_mode_o |=> eeprom_fetch_o && eeprom_addr_o == $past(info_pci_addr_i[7:0]))
    else $error("bad fetch");
  chk_base_zero: assert property (card_mode_o |=> info_base_rdata_o == 32'h0000_0000)
    else $error("base not zero");
  cover property (ptr_rd && card_mode_o);
  cover property (ptr_rd && !card_mode_o);
  cover property (info_rd_i && !card_mode_o);
endmodule // pcics_regs_sva

// ===== verification/pcics_host.sv
// Host model issuing one-cycle configuration strobes.
// Assumes the bench calls acc; released data shows its inverse.
`timescale 1ns/10ps
module pcics_host (
  // Clock
  input  wire        clk_i,
  // Configuration request
  output reg         rd_o,
  output reg         wr_o,
  output reg  [7:0]  addr_o,
  output reg  [31:0] wdata_o
);
  initial {rd_o, wr_o, addr_o, wdata_o} = 42'h0;
  // One cycle read or write, launched on the falling edge
  task acc(input w, input [7:0] a, input [31:0] d);
    begin
      @(negedge clk_i);
      {rd_o, wr_o, addr_o, wdata_o} = {!w, w, a, d};
      @(negedge clk_i);
      {rd_o, wr_o, wdata_o} = {2'b00, ~d};
    end
  endtask
endmodule // pcics_host

// ===== verification/tb_pcics_regs.sv
// Self-checking bench for pcics_regs, both strap modes.
// Assumes the host model and the bound assertion checker.
`timescale 1ns/10ps
module tb_pcics_regs;
  reg          clk_i, rst_n_i = 0, strap = 0, ld = 0, info_rd = 0;
  reg  [4:0]   off = 0;
  reg  [31:0]  sub = 0, pa = 0, pm1 = 0, pm2 = 0, x = 18;
  wire         rd, wr, rv, fetch, mode;
  wire [7:0]   a, ea;
  wire [31:0]  wd, rdat, brd;
  integer      err_count = 0, compares = 0, i;
  pcics_host host_inst (.clk_i(clk_i), .rd_o(rd), .wr_o(wr), .addr_o(a), .wdata_o(wd));
  pcics_regs pcics_regs_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .card_mode_strap_i(strap), .cfg_rd_i(rd),
    .cfg_wr_i(wr), .cfg_addr_i(a), .cfg_wdata_i(wd), .cfg_rdata_o(rdat), .cfg_rvalid_o(rv),
    .eeprom_offset_load_i(ld), .eeprom_info_offset_i(off), .eeprom_subsys_load_i(ld), .eeprom_subsys_i(sub),
    .info_rd_i(info_rd), .info_pci_addr_i(pa), .eeprom_fetch_o(fetch), .eeprom_addr_o(ea),
    .info_base_rdata_o(brd), .info_base_reg_i(pm2), .pm_first_rdata_i(pm1), .pm_second_rdata_i(pm2),
    .card_mode_o(mode));
  function [31:0] nx(input [31:0] v);
    begin
      nx = v ^ (v << 13);
      nx = nx ^ (nx >> 17);
      nx = nx ^ (nx << 5);
    end
  endfunction
  // Expected pointer word for a strap level and offset
  function [31:0] ptr_exp(input m, input [4:0] o);
    ptr_exp = m ? 32'h0000_0000 : {24'h0, o, 3'h3};
  endfunction
  task chk(input [47:0] n, input [31:0] ex, input [31:0] got);
    begin
      compares = compares + 1;
      if (got !== ex) begin
        err_count = err_count + 1;
        $display("MISMATCH %0s exp %h got %h", n, ex, got);
      end
    end
  endtask
  task rdc(input [7:0] ad, input [31:0] ex);
    begin
      host_inst.acc(1'b0, ad, 32'h0);
      chk("rvalid", 32'h1, {31'h0, rv});
      chk("rdata", ex, rdat);
    end
  endtask
  task complete_run;
    begin
      $display("Compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial begin
    clk_i = 0;
    forever #5 clk_i = ~clk_i;
  end
  // Watchdog against a hang
  initial begin
    #100000 err_count = err_count + 1;
    complete_run;
  end
  // Both strap levels, random contents, corner writes
  initial begin
    for (i = 0; i < 2; i = i + 1) begin
      strap = i[0];
      rst_n_i = 0;
      repeat (2) @(negedge clk_i);
      chk("rstrd", 32'h0000_0000, rdat);
      rst_n_i = 1;
      @(negedge clk_i);
      x = nx(x); off = x[4:0]; x = nx(x); sub = x; ld = 1;
      @(negedge clk_i) ld = 0;
      rdc(8'h28, ptr_exp(i[0], off));
      rdc(8'h2C, sub);
      x = nx(x); host_inst.acc(1'b1, 8'hF8, x); rdc(8'h2C, x);
      host_inst.acc(1'b1, 8'h2C, ~x); host_inst.acc(1'b1, 8'h28, ~x); host_inst.acc(1'b1, 8'h34, ~x);
      rdc(8'h2C, x);
      rdc(8'h28, ptr_exp(i[0], off));
      rdc(8'h34, 32'h0000_0044);
      rdc(8'h3C, 32'h0000_0000);
      pm1 = nx(x); pm2 = nx(pm1); pa = nx(pm2);
      rdc(8'h44, pm1); rdc(8'h48, pm2);
      chk("base", i ? 32'h0 : pm2 & 32'hFFFF_F800, brd);
      chk("mode", {31'h0, i[0]}, {31'h0, mode});
      info_rd = 1;
      @(negedge clk_i) info_rd = 0;
      chk("fetch", {31'h0, !i[0]}, {31'h0, fetch});
      if (!i[0]) chk("eaddr", {24'h0, pa[7:0]}, {24'h0, ea});
      $display("Test with strap %0d done", i);
    end
    complete_run;
  end
endmodule // tb_pcics_regs
bind pcics_regs pcics_regs_sva pcics_regs_sva_inst (.clk_i, .rst_n_i, .card_mode_o, .cfg_rd_i, .cfg_addr_i,
  .cfg_rdata_o, .pm_first_rdata_i, .info_rd_i, .info_pci_addr_i, .eeprom_fetch_o, .eeprom_addr_o, .info_base_rdata_o);
